// >>> logic/isa_map.svh
`ifndef ISA_MAP_SVH
`define ISA_MAP_SVH

// Register indices; the byte address on the bus is four times the index.
`define ISA_IDX_PRIMARY 6'h02
`define ISA_IDX_RANGE 6'h03
`define ISA_IDX_DATA 6'h04
`define ISA_IDX_CTL 6'h05
`define ISA_IDX_STATUS 6'h08

// Field positions of slave_addressing_control.
`define ISA_CTL_GCEN 7
`define ISA_CTL_WIDE 6
`define ISA_CTL_DRIVE 5
`define ISA_CTL_RATE 4
`define ISA_CTL_RANGE 3
`define ISA_CTL_HI_MSB 2

// Reset values.
`define ISA_CTL_RST 8'h00
`define ISA_ADDR_RST 7'h00
`define ISA_BYTE_RST 8'h00

// Fixed bus codes.
`define ISA_GC_ADDR 8'h00
`define ISA_TENBIT_HDR 5'h1E
`define ISA_ACK_BIT 4'h8
// Bit count loaded at a start; the SCL fall that closes the start wraps it
// to zero, so that fall is not taken for a data bit.
`define ISA_PRE_BIT 4'hF
`define ISA_LAST_BIT 4'h7

`endif

// >>> logic/isa_pkg.sv
package isa_pkg;

	typedef enum logic [1:0] {
		ISA_IDLE = 2'b00,
		ISA_ADDR = 2'b01,
		ISA_ADDR2 = 2'b10,
		ISA_DATA = 2'b11
	} isa_state_t;

	typedef struct packed {
		logic [7:0] ctl;
		logic [6:0] a1;
		logic [6:0] ra;
		isa_state_t st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] rx;
		logic rx_full;
		logic [7:0] tx;
		logic tx_valid;
		logic m10;
		logic addressed;
		logic rw;
		logic gc;
		logic ovr;
		logic scl_p;
		logic sda_p;
		logic sda_oe;
		logic scl_oe;
		logic drive_hi;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} isa_regs_t;

endpackage

// >>> logic/isa_slave_addr.sv
// Chosen here: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "isa_map.svh"

module isa_slave_addr (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic pad_drive_high
);
	import isa_pkg::*;

	isa_regs_t q;
	isa_regs_t d;

	// Byte address of a register index; used by every decode below.
	function automatic logic [7:0] addr_of(input logic [5:0] idx);
		addr_of = {idx, 2'b00};
	endfunction

	// Pins only ever pull low, so the driven level is a constant zero.
	assign prdata = q.prdata;
	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = q.scl_oe;
	assign sda_oe = q.sda_oe;
	assign pad_drive_high = q.drive_hi;

	// Next-state logic for the bus slave and the I2C address engine.
	always_comb begin
		logic setup;
		logic acc;
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
		logic hit;
		logic [6:0] a7;
		setup = psel & penable & ~q.pready;
		acc = psel & penable & q.pready;
		scl_rise = scl_in & ~q.scl_p;
		scl_fall = ~scl_in & q.scl_p;
		start = scl_in & q.scl_p & q.sda_p & ~sda_in;
		stop = scl_in & q.scl_p & ~q.sda_p & sda_in;
		hit = 1'b0;
		a7 = q.sh[7:1];
		d = q;
		d.scl_p = scl_in;
		d.sda_p = sda_in;
		// One wait state: data and error are registered on the same edge as pready.
		d.pready = setup;
		d.pslverr = 1'b0;
		if (setup) begin
			d.prdata = 32'h0;
			if (paddr == addr_of(`ISA_IDX_CTL)) begin
				d.prdata = {24'h0, q.ctl};
			end else if (paddr == addr_of(`ISA_IDX_PRIMARY)) begin
				d.prdata = {24'h0, q.a1, 1'b0};
			end else if (paddr == addr_of(`ISA_IDX_RANGE)) begin
				d.prdata = {24'h0, q.ra, 1'b0};
			end else if (paddr == addr_of(`ISA_IDX_DATA)) begin
				d.prdata = {24'h0, q.rx};
			end else if (paddr == addr_of(`ISA_IDX_STATUS)) begin
				d.prdata = {25'h0, q.scl_oe, q.ovr, q.gc, ~q.tx_valid,
					q.rx_full, q.rw, q.addressed};
			end else begin
				d.pslverr = 1'b1;
			end
		end
		// Writes and read side effects land on the edge that completes access.
		if (acc & pwrite) begin
			if (paddr == addr_of(`ISA_IDX_CTL)) begin
				d.ctl = pwdata[7:0];
			end else if (paddr == addr_of(`ISA_IDX_PRIMARY)) begin
				d.a1 = pwdata[7:1];
			end else if (paddr == addr_of(`ISA_IDX_RANGE)) begin
				d.ra = pwdata[7:1];
			end else if (paddr == addr_of(`ISA_IDX_DATA)) begin
				d.tx = pwdata[7:0];
				d.tx_valid = 1'b1;
			end
		end else if (acc & (paddr == addr_of(`ISA_IDX_DATA))) begin
			d.rx_full = 1'b0;
		end
		d.drive_hi = d.ctl[`ISA_CTL_DRIVE];
		// Bus engine runs after software so a hardware set beats a clear.
		if (stop) begin
			d.st = ISA_IDLE;
			d.sda_oe = 1'b0;
			d.scl_oe = 1'b0;
			d.addressed = 1'b0;
			d.m10 = 1'b0;
		end else if (start) begin
			// A repeated start keeps m10 so a 10-bit read can follow.
			d.st = ISA_ADDR;
			d.cnt = `ISA_PRE_BIT; // First fall after a start carries no bit.
			d.sda_oe = 1'b0;
			d.scl_oe = 1'b0;
			d.addressed = 1'b0;
			d.gc = 1'b0;
			d.ovr = 1'b0;
		end else if (q.st != ISA_IDLE) begin
			if (q.scl_oe) begin
				// SCL is held low; let go once the data register is served.
				if (q.rw ? q.tx_valid : ~q.rx_full) begin
					d.scl_oe = 1'b0;
					if (q.rw) begin
						d.sh = q.tx;
						d.tx_valid = 1'b0;
						d.sda_oe = ~q.tx[7];
					end
				end
			end else if (scl_rise && q.cnt < `ISA_ACK_BIT &&
				!(q.st == ISA_DATA && q.rw)) begin
				d.sh = {q.sh[6:0], sda_in};
			end else if (scl_rise && q.cnt == `ISA_ACK_BIT &&
				q.st == ISA_DATA && q.rw && sda_in) begin
				// Master refused the byte: stay off the bus until the next start or stop.
				d.st = ISA_IDLE;
			end else if (scl_fall && q.cnt == `ISA_LAST_BIT) begin
				d.cnt = `ISA_ACK_BIT;
				d.sda_oe = 1'b0;
				case (q.st)
					ISA_ADDR: begin
						if (q.ctl[`ISA_CTL_GCEN] &&
							q.sh == `ISA_GC_ADDR) begin
							d.gc = 1'b1;
							d.addressed = 1'b1;
							d.rw = 1'b0;
							d.st = ISA_DATA;
							d.sda_oe = 1'b1;
						end else if (!q.ctl[`ISA_CTL_WIDE]) begin
							// 7-bit: the high field plays no part here.
							hit = (a7 == q.a1) ||
								(q.ctl[`ISA_CTL_RANGE] && a7 > q.a1 &&
								a7 <= q.ra);
							d.addressed = hit;
							d.rw = q.sh[0];
							d.st = hit ? ISA_DATA : ISA_IDLE;
							d.sda_oe = hit;
						end else if (q.sh[7:3] == `ISA_TENBIT_HDR &&
							q.sh[2:1] == q.ctl[`ISA_CTL_HI_MSB -: 2]) begin
							// 10-bit header: write goes on, read needs m10.
							hit = ~q.sh[0] | q.m10;
							d.st = !hit ? ISA_IDLE :
								(q.sh[0] ? ISA_DATA : ISA_ADDR2);
							d.addressed = hit & q.sh[0];
							d.rw = q.sh[0];
							d.sda_oe = hit;
						end else begin
							d.st = ISA_IDLE;
						end
					end
					ISA_ADDR2: begin
						hit = q.sh == {q.ctl[0], q.a1};
						d.m10 = hit;
						d.addressed = hit;
						d.rw = 1'b0;
						d.st = hit ? ISA_DATA : ISA_IDLE;
						d.sda_oe = hit;
					end
					default: begin
						// Received byte goes to the data register unless it is full; then it is dropped and ovr is set.
						if (!q.rw) begin
							if (q.rx_full) begin
								d.ovr = 1'b1;
							end else begin
								d.rx = q.sh;
								d.rx_full = 1'b1;
							end
							d.sda_oe = 1'b1;
						end
					end
				endcase
			end else if (scl_fall && q.cnt == `ISA_ACK_BIT) begin
				d.cnt = 4'h0;
				d.sda_oe = 1'b0;
				if (q.st == ISA_DATA && q.rw) begin
					// Transmit always waits for a byte; nothing else to send.
					if (q.tx_valid) begin
						d.sh = q.tx;
						d.tx_valid = 1'b0;
						d.sda_oe = ~q.tx[7];
					end else begin
						d.scl_oe = 1'b1;
					end
				end else if (q.st == ISA_DATA) begin
					// Only rate independence stretches on receive; else overrun.
					d.scl_oe = q.ctl[`ISA_CTL_RATE] & d.rx_full;
				end
			end else if (scl_fall) begin
				d.cnt = q.cnt + 4'h1;
				if (q.st == ISA_DATA && q.rw) begin
					d.sh = {q.sh[6:0], 1'b0};
					d.sda_oe = ~q.sh[6];
				end
			end
		end
	end

	// All state is registered here; reset loads constants only.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '{ctl: `ISA_CTL_RST, a1: `ISA_ADDR_RST, ra: `ISA_ADDR_RST,
				st: ISA_IDLE, cnt: 4'h0, sh: `ISA_BYTE_RST, rx: `ISA_BYTE_RST,
				tx: `ISA_BYTE_RST, scl_p: 1'b1, sda_p: 1'b1, prdata: 32'h0,
				default: 1'b0};
		end else begin
			q <= d;
		end
	end
endmodule
`default_nettype wire

// >>> tb/isa_checker.sv
`timescale 1ns/1ns
`default_nettype none
module isa_checker (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic scl_in,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic pad_drive_high
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Bus answers are one-cycle pulses after a single wait state.
	ans_time_a: assert property (psel && !penable |-> ##[1:3] pready)
		else $error("answer late");
	ans_pulse_a: assert property (pready |=> !pready)
		else $error("ready too long");
	ans_idle_a: assert property (!psel |-> !pready)
		else $error("ready without request");
	err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("bad error answer");
	map_err_a: assert property (pready && !(paddr inside
		{8'h08, 8'h0C, 8'h10, 8'h14, 8'h20}) |-> pslverr)
		else $error("unmapped not refused");
	drive_copy_a: assert property (psel && penable && pready && pwrite &&
		paddr == 8'h14 |=> pad_drive_high == $past(pwdata[5]))
		else $error("drive bit not copied");
	// Pins only ever pull low, SDA's enable changes only while SCL is low, and a stretch starts only with SCL low.
	open_drain_a: assert property (!scl_out && !sda_out)
		else $error("pin driven high");
	sda_edge_a: assert property ($changed(sda_oe) |-> !scl_in)
		else $error("data moved with SCL high");
	stretch_low_a: assert property ($rose(scl_oe) |-> !scl_in)
		else $error("stretch began with SCL high");
	cover property (pslverr);
	cover property (sda_oe);
	cover property (pad_drive_high);
	cover property ($rose(scl_oe));
endmodule
bind isa_slave_addr isa_checker chk (.*);
`default_nettype wire

// >>> tb/isa_i2c_master.sv
`timescale 1ns/1ns
`default_nettype none
module isa_i2c_master (
	input wire logic pclk,
	input wire logic scl,
	input wire logic sda,
	output logic scl_m,
	output logic sda_m
);
	// Both lines released at power up; high means released.
	initial begin
		scl_m = 1'b1;
		sda_m = 1'b1;
	end
	task automatic hold();
		repeat (16) @(posedge pclk);
	endtask
	// Release SCL and wait while the slave stretches it.
	task automatic hi();
		scl_m <= 1'b1;
		do @(posedge pclk); while (scl !== 1'b1);
		hold();
	endtask
	task automatic start();
		sda_m <= 1'b1;
		hi();
		sda_m <= 1'b0;
		hold();
		scl_m <= 1'b0;
		hold();
	endtask
	task automatic stop();
		sda_m <= 1'b0;
		hold();
		hi();
		sda_m <= 1'b1;
		hold();
	endtask
	// Sends MSB first, then samples the ninth bit.
	task automatic send(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sda_m <= b[i];
			hold();
			hi();
			scl_m <= 1'b0;
		end
		sda_m <= 1'b1;
		hold();
		hi();
		ack = !sda;
		scl_m <= 1'b0;
	endtask
	// Reads a byte MSB first, then answers ACK (1) or NACK (0).
	task automatic recv(output logic [7:0] b, input logic ack);
		sda_m <= 1'b1;
		for (int i = 7; i >= 0; i--) begin
			hold();
			hi();
			b[i] = sda;
			scl_m <= 1'b0;
		end
		sda_m <= !ack;
		hold();
		hi();
		scl_m <= 1'b0;
	endtask
endmodule
`default_nettype wire

// >>> tb/i2c_slave_address_config_bench.sv
`timescale 1ns/1ns
`default_nettype none
module i2c_slave_address_config_bench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, r;
	logic pready, pslverr, scl_oe, sda_oe, scl_m, sda_m, pdh, e, a;
	logic [7:0] b;
	int fails = 0, checked = 0;
	// Each entry: control value, address byte, expected ACK.
	logic [23:0] tv [10] = '{24'h27A001, 24'h27A200, 24'h270000,
		24'h880001, 24'h88A201, 24'h88A401, 24'h88A600, 24'h88A001,
		24'h45F600, 24'h45A000};
	// Open-drain lines with pull-ups.
	wire scl = scl_m & ~scl_oe;
	wire sda = sda_m & ~sda_oe;
	always #4 pclk = ~pclk;
	isa_slave_addr uut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .scl_in(scl),
		.scl_out(), .scl_oe, .sda_in(sda), .sda_out(), .sda_oe,
		.pad_drive_high(pdh));
	isa_i2c_master m (.pclk, .scl, .sda, .scl_m, .sda_m);
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		checked++;
		if (s !== x) begin
			fails++;
			$display("MISMATCH %0t seen %h want %h", $time, s, x);
		end
	endtask
	// One bus access; held until ready is seen at an edge.
	task automatic apb(input logic w, input logic [7:0] ad,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		while (pready !== 1'b1) @(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic test_done();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// Main sequence: registers, address matching, ten-bit transfer, stretching, slave transmit.
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 8'h14, 0);
		chk(r, 32'h0);
		apb(0, 8'h18, 0);
		chk(e, 1);
		apb(1, 8'h08, 32'hA0);
		apb(1, 8'h0C, 32'hA4);
		apb(1, 8'h14, 32'h27);
		apb(0, 8'h14, 0);
		chk(r, 32'h27);
		chk(pdh, 1);
		$display("test registers done");
		foreach (tv[i]) begin
			apb(1, 8'h14, tv[i][23:16]);
			m.start();
			m.send(tv[i][15:8], a);
			m.stop();
			chk(a, tv[i][0]);
		end
		$display("test matching done");
		apb(1, 8'h14, 32'h45);
		m.start();
		m.send(8'hF4, a);
		chk(a, 1);
		m.send(8'hD0, a);
		chk(a, 1);
		m.send(8'h3C, a);
		m.stop();
		apb(0, 8'h10, 0);
		chk(r, 32'h3C);
		chk(pdh, 0);
		$display("test ten bit done");
		// Rate independence: a full data register holds SCL low.
		apb(1, 8'h14, 32'h10);
		m.start();
		m.send(8'hA0, a);
		m.send(8'h5A, a);
		repeat (4) @(posedge pclk);
		chk(scl_oe, 1);
		fork
			m.send(8'h66, a);
			apb(0, 8'h10, 0);
		join
		chk(r, 32'h5A);
		chk(a, 1);
		apb(0, 8'h10, 0);
		chk(r, 32'h66);
		m.stop();
		$display("test stretch done");
		// Slave transmit: a byte loaded beforehand goes out MSB first.
		apb(1, 8'h14, 32'h00);
		apb(1, 8'h10, 32'hC5);
		m.start();
		m.send(8'hA1, a);
		chk(a, 1);
		m.recv(b, 1'b0);
		m.stop();
		chk(b, 32'hC5);
		$display("test transmit done");
		test_done();
	end
	// Watchdog well beyond the expected run length.
	initial begin
		#600000;
		fails++;
		test_done();
	end
endmodule
`default_nettype wire
